// >>> hdl/bus_access_defs.svh
/*
  Constants for the bus address and access security block.
  Assumes inclusion by bare name from the access security design module.
*/
//
// Contract
// - Separate I2C and PMBus seven-bit addresses answered
// - Offset enable bit gates strap offset
// - Strap decodes sixteen offsets, added arithmetically
// - Same offset applied to PMBus address
// - Address locked once determined
// - Default config set with enable and alarm low forces default addresses
// - Read security selects four levels
// - Write security selects three levels
// - Unlock by password, pin, both, never
// - Sixteen-bit password, zero never valid
// - Matching attempt high and low unlocks
// - Four wrong attempts lock up permanently
// - New password high byte relocks device
// - New low byte leaves device locked
// - Report telemetry, output voltage from code
// - Input current fixed and per-phase offsets
// - Output current fixed offset, eighth amp
// - Output voltage offset, mode-dependent step
// - Temperature offset plus31 to minus32
// - Strap sampled once at enable
`ifndef BUS_ACCESS_DEFS_SVH
`define BUS_ACCESS_DEFS_SVH

`define FORCED_I2C_ADDR     7'h0A
`define FORCED_PMBUS_ADDR   7'h0D
`define MAX_BAD_TRIES       3'h4
`define PW_ZERO             16'h0000
`define TRY_RESET           16'h0000
`define IDX_TRY_HI          8'h00
`define IDX_TRY_LO          8'h01
`define IDX_PW_HI           8'h02
`define IDX_PW_LO           8'h03
`define VOUT_STEP_FINE_MV   10'h005
`define VOUT_STEP_COARSE_MV 10'h00A

`endif

// >>> hdl/bus_access_pkg.sv
/*
  Types for the bus address and access security block.
  Assumes the constants header is available on the include path.
*/
package bus_access_pkg;
  typedef enum logic [1:0] {
    rd_open       = 2'h0,
    rd_cfg        = 2'h1,
    rd_all_but_tm = 2'h2,
    rd_all        = 2'h3
  } rd_sec_t;

  typedef enum logic [1:0] {
    wr_open = 2'h0,
    wr_cfg  = 2'h1,
    wr_all  = 2'h2
  } wr_sec_t;

  typedef enum logic [1:0] {
    unl_password = 2'h0,
    unl_pin      = 2'h1,
    unl_both     = 2'h2,
    unl_never    = 2'h3
  } unlock_mode_t;

  typedef enum logic [1:0] {
    cls_telemetry = 2'h0,
    cls_config    = 2'h1,
    cls_other     = 2'h2
  } reg_class_t;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_armed  = 3'b010,
    st_locked = 3'b100
  } addr_state_t;
endpackage

// >>> hdl/telemetry_offset.sv
/*
  Applies a signed calibration offset to one telemetry word, saturating.
  Assumes raw and offset share the same LSB weight.
*/
`timescale 1ns/1ps
module telemetry_offset #(
  parameter int W = 16
) (
  // Data
  input  wire logic [W-1:0] i_raw,
  input  wire logic [W-1:0] i_offset,
  output logic      [W-1:0] o_corrected
);
  logic [W:0] sum;

  always_comb begin
    sum = {1'b0, i_raw} + {i_offset[W-1], i_offset};
    if (i_offset[W-1] && sum[W]) begin
      o_corrected = '0;
    end else if (!i_offset[W-1] && sum[W]) begin
      o_corrected = '1;
    end else begin
      o_corrected = sum[W-1:0];
    end
  end
endmodule

// >>> hdl/bus_access_security.sv
/*
  Slave-side address selection and access security for the I2C and PMBus port,
  plus calibration of reported telemetry.
  Assumes the protocol engine presents decoded register accesses as one-cycle
  strobes with a class tag, and nonvolatile settings arrive as static inputs.
*/
`timescale 1ns/1ps
`include "bus_access_defs.svh"
module bus_access_security (
  // Clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst,
  // Pins
  input  wire logic                        i_enable,
  input  wire logic                        i_thermal_alarm_pin_n,
  input  wire logic [3:0]                  i_strap_code,
  input  wire logic                        i_protect_pin,
  // Nonvolatile store settings
  input  wire logic                        i_default_config,
  input  wire logic                        i_offset_en,
  input  wire logic [6:0]                  i_i2c_base_addr,
  input  wire logic [6:0]                  i_pmbus_base_addr,
  input  wire bus_access_pkg::rd_sec_t     i_rd_sec,
  input  wire bus_access_pkg::wr_sec_t     i_wr_sec,
  input  wire bus_access_pkg::unlock_mode_t i_unlock_mode,
  input  wire logic [15:0]                 i_unlock_secret_store,
  // Register access from protocol engine
  input  wire logic                        i_wr_stb,
  input  wire logic                        i_rd_stb,
  input  wire bus_access_pkg::reg_class_t  i_class,
  input  wire logic [7:0]                  i_sec_idx,
  input  wire logic [7:0]                  i_wr_data,
  input  wire logic [7:0]                  i_rd_data_raw,
  output logic                             o_wr_allow,
  output logic [7:0]                       o_rd_data,
  output logic                             o_pw_hi_wr,
  output logic                             o_pw_lo_wr,
  // Addresses
  output logic [6:0]                       o_i2c_addr,
  output logic [6:0]                       o_pmbus_addr,
  // Security status
  output logic                             o_unlocked,
  output logic                             o_lockout,
  output logic [15:0]                      o_unlock_attempt,
  // Telemetry
  input  wire logic                        i_vout_coarse_mode,
  input  wire logic [15:0]                 i_vout_code_mv,
  input  wire logic [15:0]                 i_loadline_drop_mv,
  input  wire logic [15:0]                 i_vin_raw,
  input  wire logic [15:0]                 i_iin_raw_128,
  input  wire logic [15:0]                 i_output_current_raw_8,
  input  wire logic [15:0]                 i_temp_raw,
  input  wire logic [3:0]                  i_active_phases,
  input  wire logic [7:0]                  i_iin_fixed_off_32,
  input  wire logic [7:0]                  i_iin_phase_off_128,
  input  wire logic [4:0]                  i_output_current_off_8,
  input  wire logic [3:0]                  i_vout_off_steps,
  input  wire logic [5:0]                  i_temp_off,
  output logic [15:0]                      o_vin,
  output logic [15:0]                      o_input_current,
  output logic [15:0]                      o_output_current,
  output logic [15:0]                      o_vout,
  output logic [15:0]                      o_temp
);
  import bus_access_pkg::*;

  addr_state_t st, next_st;
  logic [6:0]  i2c_addr, next_i2c_addr, pm_addr, next_pm_addr;
  logic [3:0]  strap, next_strap;
  logic        enable_d, next_enable_d;
  logic [6:0]  addr_off;

  // Strap offset joins the base addresses only when enabled
  assign addr_off = i_offset_en ? {3'h0, strap} : 7'h00;

  // Address determination
  always_comb begin
    next_st       = st;
    next_i2c_addr = i2c_addr;
    next_pm_addr  = pm_addr;
    next_strap    = strap;
    next_enable_d = i_enable;
    case (st)
      st_idle: begin
        if (i_enable && !enable_d) begin
          next_strap = i_strap_code;
          next_st    = st_armed;
        end
      end
      st_armed: begin
        next_i2c_addr = 7'(i_i2c_base_addr + addr_off);
        next_pm_addr  = 7'(i_pmbus_base_addr + addr_off);
        next_st       = st_locked;
      end
      st_locked: begin
        if (!i_enable) begin
          next_st = st_idle;
        end
      end
      default: next_st = st_idle;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st       <= st_idle;
      i2c_addr <= 7'h00;
      pm_addr  <= 7'h00;
      strap    <= 4'h0;
      enable_d <= 1'b0;
    end else begin
      st       <= next_st;
      i2c_addr <= next_i2c_addr;
      pm_addr  <= next_pm_addr;
      strap    <= next_strap;
      enable_d <= next_enable_d;
    end
  end

  // Default addresses with default config set, while disabled with the alarm pin low
  logic forced;
  assign forced = i_default_config && !i_enable && !i_thermal_alarm_pin_n;
  assign o_i2c_addr   = forced ? `FORCED_I2C_ADDR : i2c_addr;
  assign o_pmbus_addr = forced ? `FORCED_PMBUS_ADDR : pm_addr;

  // Password unlock state
  logic [15:0] attempt, next_attempt;
  logic        pw_match, next_pw_match;
  logic [2:0]  bad, next_bad;
  logic        lockout;
  logic        pw_valid;
  logic        sec_wr;

  assign lockout  = (bad == `MAX_BAD_TRIES);
  assign pw_valid = (i_unlock_secret_store != `PW_ZERO);
  assign sec_wr   = i_wr_stb && (i_class == cls_config);

  always_comb begin
    next_attempt  = attempt;
    next_pw_match = pw_match;
    next_bad      = bad;
    // Enable low drops the unlock; a matching try in that cycle still wins
    if (!i_enable) begin
      next_pw_match = 1'b0;
    end
    if (sec_wr && !lockout) begin
      case (i_sec_idx)
        `IDX_TRY_HI: begin
          next_attempt = {i_wr_data, attempt[7:0]};
          next_pw_match = 1'b0;
        end
        `IDX_TRY_LO: begin
          next_attempt = {attempt[15:8], i_wr_data};
          if (pw_valid && ({attempt[15:8], i_wr_data} == i_unlock_secret_store)) begin
            next_pw_match = 1'b1;
          end else begin
            next_pw_match = 1'b0;
            next_bad      = bad + 3'h1;
          end
        end
        `IDX_PW_HI: begin
          if (o_wr_allow) begin
            next_pw_match = 1'b0;
          end
        end
        `IDX_PW_LO: begin
          if (o_wr_allow) begin
            next_pw_match = 1'b0;
          end
        end
        default: next_attempt = attempt;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      attempt  <= `TRY_RESET;
      pw_match <= 1'b0;
      bad      <= 3'h0;
    end else begin
      attempt  <= next_attempt;
      pw_match <= next_pw_match;
      bad      <= next_bad;
    end
  end

  // Unlock method
  logic unlocked;
  always_comb begin
    case (i_unlock_mode)
      unl_password: unlocked = pw_match;
      unl_pin:      unlocked = i_protect_pin && (st == st_locked);
      unl_both:     unlocked = pw_match && i_protect_pin && (st == st_locked);
      unl_never:    unlocked = 1'b0;
      default:      unlocked = 1'b0;
    endcase
  end

  // Access gating
  logic sec_idx_hit, wr_prot, rd_prot;
  assign sec_idx_hit = (i_class == cls_config) &&
                       ((i_sec_idx == `IDX_TRY_HI) || (i_sec_idx == `IDX_TRY_LO));

  always_comb begin
    case (i_wr_sec)
      wr_open: wr_prot = 1'b0;
      wr_cfg:  wr_prot = (i_class == cls_config);
      wr_all:  wr_prot = 1'b1;
      default: wr_prot = 1'b1;
    endcase
    case (i_rd_sec)
      rd_open:       rd_prot = 1'b0;
      rd_cfg:        rd_prot = (i_class == cls_config);
      rd_all_but_tm: rd_prot = (i_class != cls_telemetry);
      rd_all:        rd_prot = 1'b1;
      default:       rd_prot = 1'b1;
    endcase
  end

  // Attempt registers stay writable so a locked host can still unlock
  assign o_wr_allow = i_wr_stb && (sec_idx_hit || !wr_prot || unlocked);
  assign o_pw_hi_wr = o_wr_allow && (i_class == cls_config) && (i_sec_idx == `IDX_PW_HI);
  assign o_pw_lo_wr = o_wr_allow && (i_class == cls_config) && (i_sec_idx == `IDX_PW_LO);

  // Read data is blanked while its class is protected and locked
  logic [7:0] rd_data, next_rd_data;
  always_comb begin
    next_rd_data = rd_data;
    if (i_rd_stb) begin
      next_rd_data = (rd_prot && !unlocked) ? 8'h00 : i_rd_data_raw;
    end
  end

  // Telemetry calibration
  logic [15:0] iin_off, output_current_off, vout_off, temp_off, vout_raw, step_mv;
  logic [15:0] vout_scaled;
  logic [15:0] vin_n, iin_n, output_current_n, vout_n, temp_n;
  logic [15:0] vin_r, iin_r, output_current_r, vout_r, temp_r;

  always_comb begin
    step_mv  = {6'h00, i_vout_coarse_mode ? `VOUT_STEP_COARSE_MV : `VOUT_STEP_FINE_MV};
    vout_raw = i_vout_code_mv - i_loadline_drop_mv;
    iin_off  = {6'h00, i_iin_fixed_off_32, 2'h0} +
               16'(i_iin_phase_off_128 * i_active_phases);
    output_current_off = {{11{i_output_current_off_8[4]}}, i_output_current_off_8};
    vout_scaled = 16'($signed({{12{i_vout_off_steps[3]}}, i_vout_off_steps}) * $signed(step_mv));
    // Most negative code gives the positive end of the range
    vout_off = 16'h0000 - vout_scaled;
    temp_off = {{10{i_temp_off[5]}}, i_temp_off};
  end

  telemetry_offset #(.W(16)) u_iin (
    .i_raw      (i_iin_raw_128),
    .i_offset   (iin_off),
    .o_corrected(iin_n)
  );
  telemetry_offset #(.W(16)) u_output_current (
    .i_raw      (i_output_current_raw_8),
    .i_offset   (output_current_off),
    .o_corrected(output_current_n)
  );
  telemetry_offset #(.W(16)) u_vout (
    .i_raw      (vout_raw),
    .i_offset   (vout_off),
    .o_corrected(vout_n)
  );
  telemetry_offset #(.W(16)) u_temp (
    .i_raw      (i_temp_raw),
    .i_offset   (temp_off),
    .o_corrected(temp_n)
  );
  assign vin_n = i_vin_raw;

  // Output registers for read data and telemetry
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_data <= 8'h00;
      vin_r   <= 16'h0000;
      iin_r   <= 16'h0000;
      output_current_r  <= 16'h0000;
      vout_r  <= 16'h0000;
      temp_r  <= 16'h0000;
    end else begin
      rd_data <= next_rd_data;
      vin_r   <= vin_n;
      iin_r   <= iin_n;
      output_current_r  <= output_current_n;
      vout_r  <= vout_n;
      temp_r  <= temp_n;
    end
  end

  assign o_rd_data        = rd_data;
  assign o_unlocked       = unlocked;
  assign o_lockout        = lockout;
  assign o_unlock_attempt = attempt;
  assign o_vin            = vin_r;
  assign o_input_current  = iin_r;
  assign o_output_current = output_current_r;
  assign o_vout           = vout_r;
  assign o_temp           = temp_r;
endmodule

// >>> testbench/bus_access_checker.sv
/*
  Concurrent checks on the ports of the access security block, bound into it.
  Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module bus_access_checker
  import bus_access_pkg::*;
(
  input wire logic                         i_clk_sys, i_rst, i_enable, i_thermal_alarm_pin_n,
  input wire logic                         i_default_config, i_wr_stb, i_rd_stb, o_wr_allow,
  input wire logic                         o_pw_hi_wr, o_unlocked, o_lockout, o_pw_lo_wr,
  input wire bus_access_pkg::unlock_mode_t i_unlock_mode,
  input wire bus_access_pkg::rd_sec_t      i_rd_sec,
  input wire bus_access_pkg::wr_sec_t      i_wr_sec,
  input wire bus_access_pkg::reg_class_t   i_class,
  input wire logic [15:0]                  i_unlock_secret_store,
  input wire logic [7:0]                   i_sec_idx, i_rd_data_raw, o_rd_data,
  input wire logic [6:0]                   o_i2c_addr, o_pmbus_addr
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  property p_forced_addr;
    i_default_config && !i_enable && !i_thermal_alarm_pin_n |->
      o_i2c_addr == 7'h0A && o_pmbus_addr == 7'h0D;
  endproperty
  a_forced_addr: assert property (p_forced_addr)
    else $error("forced address wrong");
  property p_addr_hold;
    i_enable [*4] |-> $stable(o_i2c_addr) && $stable(o_pmbus_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved while enabled");
  property p_never;
    i_unlock_mode == unl_never |-> !o_unlocked;
  endproperty
  a_never: assert property (p_never)
    else $error("unlocked in lock forever mode");
  property p_zero_pw;
    i_unlock_mode == unl_password && i_unlock_secret_store == 16'h0000 |-> !o_unlocked;
  endproperty
  a_zero_pw: assert property (p_zero_pw)
    else $error("unlocked with zero password");
  property p_lockout;
    o_lockout |=> o_lockout;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("lockout released");
  property p_pw_relock;
    o_pw_hi_wr && i_unlock_mode == unl_password |=> !o_unlocked;
  endproperty
  a_pw_relock: assert property (p_pw_relock)
    else $error("still unlocked after password high write");
  property p_pw_lo_relock;
    o_pw_lo_wr && i_unlock_mode == unl_password |=> !o_unlocked;
  endproperty
  a_pw_lo_relock: assert property (p_pw_lo_relock)
    else $error("still unlocked after password low write");
  property p_wr_block;
    i_wr_stb && i_class == cls_config && i_sec_idx > 8'h03 && i_wr_sec != wr_open &&
      !o_unlocked |-> !o_wr_allow;
  endproperty
  a_wr_block: assert property (p_wr_block)
    else $error("locked config write allowed");
  property p_rd_zero;
    i_rd_stb && i_rd_sec != rd_open && i_class == cls_config && !o_unlocked |=>
      o_rd_data == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("locked config read returned data");
  property p_rd_open;
    i_rd_stb && i_rd_sec == rd_open |=> o_rd_data == $past(i_rd_data_raw);
  endproperty
  a_rd_open: assert property (p_rd_open)
    else $error("open read data wrong");
endmodule

bind bus_access_security bus_access_checker u_chk (
  .i_clk_sys, .i_rst, .i_enable, .i_thermal_alarm_pin_n, .i_default_config, .i_wr_stb,
  .i_rd_stb, .o_wr_allow, .o_pw_hi_wr, .o_unlocked, .o_lockout, .i_unlock_mode, .i_rd_sec,
  .i_wr_sec, .i_class, .i_unlock_secret_store, .i_sec_idx, .i_rd_data_raw, .o_rd_data,
  .o_i2c_addr, .o_pmbus_addr, .o_pw_lo_wr
);

// >>> testbench/host_model.sv
/*
  Management master model: register accesses and the protect pin.
  Assumes one-cycle strobes taken on the rising clock edge.
*/
`timescale 1ns/1ps
module host_model
  import bus_access_pkg::*;
(
  // Clock and answers
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_wr_allow,
  input  wire logic [7:0]                i_rd_data,
  // Requests
  output logic                           o_wr_stb,
  output logic                           o_rd_stb,
  output bus_access_pkg::reg_class_t     o_class,
  output logic [7:0]                     o_sec_idx,
  output logic [7:0]                     o_wr_data,
  output logic                           o_protect
);
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_class = cls_other;
    o_sec_idx = 8'h00;
    o_wr_data = 8'h00;
    o_protect = 1'b0;
  end
  // High then low byte of the attempt go through here
  task automatic wr(input reg_class_t c, input logic [7:0] idx, input logic [7:0] d,
                    output logic ok);
    @(posedge i_clk_sys) #1;
    o_class = c;
    o_sec_idx = idx;
    o_wr_data = d;
    o_wr_stb = 1'b1;
    @(posedge i_clk_sys) ok = i_wr_allow;
    #1;
    o_wr_stb = 1'b0;
    o_wr_data = ~d;
  endtask
  task automatic rd(input reg_class_t c, input logic [7:0] idx, output logic [7:0] d);
    @(posedge i_clk_sys) #1;
    o_class = c;
    o_sec_idx = idx;
    o_rd_stb = 1'b1;
    @(posedge i_clk_sys) #1;
    o_rd_stb = 1'b0;
    d = i_rd_data;
  endtask
  // Only called once the strap has been taken
  task automatic pin(input logic v);
    @(posedge i_clk_sys) #1;
    o_protect = v;
    #1;
  endtask
endmodule

// >>> testbench/test_bus_access_security.sv
/*
  Self-checking bench for the access security block.
  Assumes the host model and checker compile first.
*/
`timescale 1ns/1ps
module test_bus_access_security;
  import bus_access_pkg::*;
  logic i_clk_sys, i_rst, i_enable, i_thermal_alarm_pin_n, i_default_config, i_offset_en;
  logic i_wr_stb, i_rd_stb, i_protect_pin, o_wr_allow, o_pw_hi_wr, o_pw_lo_wr, o_unlocked;
  logic o_lockout, i_vout_coarse_mode, ok;
  logic [3:0] i_strap_code, i_active_phases, i_vout_off_steps;
  logic [6:0] i_i2c_base_addr, i_pmbus_base_addr, o_i2c_addr, o_pmbus_addr;
  logic [7:0] i_sec_idx, i_wr_data, i_rd_data_raw, o_rd_data, rd;
  logic [7:0] i_iin_fixed_off_32, i_iin_phase_off_128;
  logic [4:0] i_output_current_off_8;
  logic [5:0] i_temp_off;
  logic [15:0] i_unlock_secret_store, o_unlock_attempt, i_vout_code_mv, i_loadline_drop_mv;
  logic [15:0] i_iin_raw_128, i_output_current_raw_8, i_temp_raw, o_vin, o_input_current, o_output_current;
  logic [15:0] o_vout, o_temp, i_vin_raw;
  rd_sec_t i_rd_sec;
  wr_sec_t i_wr_sec;
  unlock_mode_t i_unlock_mode;
  reg_class_t i_class;
  int error_cnt, check_count;

  bus_access_security dut (.i_clk_sys, .i_rst, .i_enable, .i_thermal_alarm_pin_n, .i_strap_code,
    .i_protect_pin, .i_default_config, .i_offset_en, .i_i2c_base_addr, .i_pmbus_base_addr,
    .i_rd_sec, .i_wr_sec, .i_unlock_mode, .i_unlock_secret_store, .i_wr_stb, .i_rd_stb, .i_class,
    .i_sec_idx, .i_wr_data, .i_rd_data_raw, .o_wr_allow, .o_rd_data, .o_pw_hi_wr, .o_pw_lo_wr,
    .o_i2c_addr, .o_pmbus_addr, .o_unlocked, .o_lockout, .o_unlock_attempt, .i_vout_coarse_mode,
    .i_vout_code_mv, .i_loadline_drop_mv, .i_vin_raw, .i_iin_raw_128, .i_output_current_raw_8, .i_temp_raw,
    .i_active_phases, .i_iin_fixed_off_32, .i_iin_phase_off_128, .i_output_current_off_8, .i_vout_off_steps,
    .i_temp_off, .o_vin, .o_input_current, .o_output_current, .o_vout, .o_temp);
  host_model host (.i_clk_sys, .i_wr_allow(o_wr_allow), .i_rd_data(o_rd_data),
    .o_wr_stb(i_wr_stb), .o_rd_stb(i_rd_stb), .o_class(i_class), .o_sec_idx(i_sec_idx),
    .o_wr_data(i_wr_data), .o_protect(i_protect_pin));

  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic try(input logic [15:0] v);
    host.wr(cls_config, 8'h00, v[15:8], ok);
    host.wr(cls_config, 8'h01, v[7:0], ok);
  endtask
  task automatic do_reset;
    i_rst = 1'b1;
    i_enable = 1'b0;
    cyc(10);
    i_rst = 1'b0;
  endtask
  initial begin
    #3_000_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {error_cnt, check_count} = '0;
    {i_thermal_alarm_pin_n, i_vout_coarse_mode} = 2'b00;
    {i_default_config, i_offset_en, i_strap_code} = {2'b11, 4'hF};
    {i_i2c_base_addr, i_pmbus_base_addr, i_rd_data_raw} = {7'h28, 7'h40, 8'hC3};
    i_rd_sec = rd_open;
    i_wr_sec = wr_open;
    i_unlock_mode = unl_password;
    i_unlock_secret_store = 16'hA55A;
    {i_vout_code_mv, i_loadline_drop_mv, i_vin_raw} = {16'h03E8, 16'h0014, 16'h1234};
    {i_iin_raw_128, i_output_current_raw_8, i_temp_raw} = {16'h03E8, 16'h0050, 16'h0032};
    {i_active_phases, i_iin_fixed_off_32, i_iin_phase_off_128} = {4'h2, 8'h02, 8'h03};
    {i_output_current_off_8, i_vout_off_steps, i_temp_off} = {5'h1F, 4'hF, 6'h3F};
    do_reset();
    chk("i2c forced", 16'h000A, {9'h000, o_i2c_addr});
    chk("pmbus forced", 16'h000D, {9'h000, o_pmbus_addr});
    i_thermal_alarm_pin_n = 1'b1;
    i_enable = 1'b1;
    cyc(3);
    chk("i2c addr", 16'h0037, {9'h000, o_i2c_addr});
    chk("pmbus addr", 16'h004F, {9'h000, o_pmbus_addr});
    i_strap_code = 4'h0;
    cyc(3);
    chk("i2c held", 16'h0037, {9'h000, o_i2c_addr});
    i_enable = 1'b0;
    i_offset_en = 1'b0;
    cyc(2);
    i_enable = 1'b1;
    cyc(3);
    chk("i2c no offset", 16'h0028, {9'h000, o_i2c_addr});
    chk("vin", 16'h1234, o_vin);
    chk("iin", 16'h03F6, o_input_current);
    chk("output_current", 16'h004F, o_output_current);
    chk("temp", 16'h0031, o_temp);
    chk("vout fine", 16'h03D9, o_vout);
    i_vout_coarse_mode = 1'b1;
    cyc(2);
    chk("vout coarse", 16'h03DE, o_vout);
    i_vout_off_steps = 4'h8;
    cyc(2);
    chk("vout top", 16'h0424, o_vout);
    host.rd(cls_config, 8'h05, rd);
    chk("open read", 16'h00C3, {8'h00, rd});
    i_rd_sec = rd_cfg;
    i_wr_sec = wr_cfg;
    host.wr(cls_config, 8'h05, 8'h11, ok);
    chk("locked write", 16'h0000, {15'h0000, ok});
    host.rd(cls_config, 8'h05, rd);
    chk("locked read", 16'h0000, {8'h00, rd});
    host.wr(cls_telemetry, 8'h05, 8'h11, ok);
    chk("telemetry write", 16'h0001, {15'h0000, ok});
    try(16'hA55A);
    chk("unlocked", 16'h0001, {15'h0000, o_unlocked});
    chk("attempt", 16'hA55A, o_unlock_attempt);
    host.rd(cls_config, 8'h05, rd);
    chk("unlocked read", 16'h00C3, {8'h00, rd});
    host.wr(cls_config, 8'h02, 8'h3C, ok);
    chk("relock hi", 16'h0000, {15'h0000, o_unlocked});
    i_unlock_secret_store = 16'h3C5A;
    try(16'h3C5A);
    chk("new hi unlock", 16'h0001, {15'h0000, o_unlocked});
    host.wr(cls_config, 8'h03, 8'h96, ok);
    chk("relock lo", 16'h0000, {15'h0000, o_unlocked});
    i_unlock_secret_store = 16'h3C96;
    host.wr(cls_config, 8'h01, 8'h96, ok);
    chk("new lo unlock", 16'h0001, {15'h0000, o_unlocked});
    repeat (3) try(16'h0001);
    chk("three bad", 16'h0000, {15'h0000, o_lockout});
    try(16'h0001);
    chk("lockout", 16'h0001, {15'h0000, o_lockout});
    try(16'h3C96);
    chk("no unlock", 16'h0000, {15'h0000, o_unlocked});
    do_reset();
    i_unlock_mode = unl_pin;
    i_enable = 1'b1;
    cyc(3);
    host.pin(1'b1);
    chk("pin unlock", 16'h0001, {15'h0000, o_unlocked});
    host.pin(1'b0);
    chk("pin lock", 16'h0000, {15'h0000, o_unlocked});
    i_unlock_mode = unl_both;
    host.pin(1'b1);
    chk("pin alone", 16'h0000, {15'h0000, o_unlocked});
    try(16'h3C96);
    chk("pin and pw", 16'h0001, {15'h0000, o_unlocked});
    i_unlock_mode = unl_never;
    cyc(1);
    chk("forever", 16'h0000, {15'h0000, o_unlocked});
    host.pin(1'b0);
    i_enable = 1'b0;
    cyc(2);
    i_enable = 1'b1;
    i_unlock_mode = unl_password;
    i_unlock_secret_store = 16'h0000;
    cyc(3);
    try(16'h0000);
    chk("zero pw", 16'h0000, {15'h0000, o_unlocked});
    print_verdict();
  end
endmodule
